// file: exec_ops.sv
// Execute stage for increment, skip, branch, inclusive OR and move operations behind APB.
`timescale 1ns/10ps
module exec_ops #(
  parameter int PADDR_W = 8
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [PADDR_W-1:0]        paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic      [ops_pkg::DATA_W-1:0] working_accumulator,
  output logic                           zero_flag,
  output logic      [ops_pkg::PC_W-1:0]   program_counter
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ops_pkg::exec_state_type        state;
    logic                           ack;
    logic                           err;
    logic [31:0]                    prdata;
    ops_pkg::opcode_type            op;
    logic                           dest;
    logic [ops_pkg::K_W-1:0]        k;
    logic [ops_pkg::DATA_W-1:0]     w;
    logic                           zero;
    logic                           skip;
    logic [ops_pkg::LATCH_W-1:0]    latch;
    logic [ops_pkg::PC_W-1:0]       pc;
    logic [ops_pkg::FILE_AW-1:0]    faddr;
    logic [ops_pkg::CYCLES_W-1:0]   cycles;
  } regs_type;

  regs_type r_r;
  regs_type r_nxt;

  logic [ops_pkg::FILE_AW-1:0] ram_raddr;
  logic [ops_pkg::DATA_W-1:0]  ram_rdata;
  logic                        ram_we;
  logic [ops_pkg::FILE_AW-1:0] ram_waddr;
  logic [ops_pkg::DATA_W-1:0]  ram_wdata;
  logic                        access;
  logic                        commit;
  logic [ops_pkg::DATA_W-1:0]  result;
  logic [ops_pkg::OP_W-1:0]    wr_op;

  function automatic logic is_mapped(input logic [PADDR_W-1:0] a);
    is_mapped = (a == PADDR_W'(ops_pkg::INSTR_OFFSET))  || (a == PADDR_W'(ops_pkg::ACCUM_OFFSET))  ||
                (a == PADDR_W'(ops_pkg::STATUS_OFFSET)) || (a == PADDR_W'(ops_pkg::LATCH_OFFSET))  ||
                (a == PADDR_W'(ops_pkg::PC_OFFSET))     || (a == PADDR_W'(ops_pkg::FADDR_OFFSET))  ||
                (a == PADDR_W'(ops_pkg::FDATA_OFFSET))  || (a == PADDR_W'(ops_pkg::CYCLES_OFFSET));
  endfunction : is_mapped

  function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] offset);
    hit = (a == PADDR_W'(offset));
  endfunction : hit

  // ****************************************
  // File memory
  // ****************************************
  // While idle the read port follows the software window address; while executing it follows the operand.
  assign ram_raddr = (r_r.state == ops_pkg::ST_IDLE) ? r_r.faddr : r_r.k[ops_pkg::FILE_AW-1:0];

  file_ram #(
    .AW (ops_pkg::FILE_AW),
    .DW (ops_pkg::DATA_W)
  ) u_file_ram (
    .pclk  (pclk),
    .ce    (ce),
    .raddr (ram_raddr),
    .rdata (ram_rdata),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata)
  );

  // ****************************************
  // Bus handshake
  // ****************************************
  // Every transfer takes one wait state; transfers wait while an instruction is in flight.
  // A low clock enable holds the answer back, so no transfer completes while its write would be lost.
  assign access  = psel && penable && !r_r.ack && (r_r.state == ops_pkg::ST_IDLE);
  assign commit  = psel && penable && r_r.ack && pwrite && !r_r.err;
  assign pready  = psel && penable && r_r.ack && ce;
  assign pslverr = pready && r_r.err;
  assign wr_op   = pwdata[ops_pkg::OP_LSB +: ops_pkg::OP_W];

  assign prdata              = r_r.prdata;
  assign working_accumulator = r_r.w;
  assign zero_flag           = r_r.zero;
  assign program_counter     = r_r.pc;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_nxt     = r_r;
    ram_we    = 1'b0;
    ram_waddr = r_r.faddr;
    ram_wdata = pwdata[ops_pkg::DATA_W-1:0];
    result    = ram_rdata;

    r_nxt.ack = access;
    if (access) begin
      r_nxt.err    = !is_mapped(paddr) ||
                     (pwrite && hit(paddr, ops_pkg::CYCLES_OFFSET)) ||
                     (pwrite && hit(paddr, ops_pkg::INSTR_OFFSET) && (wr_op > 3'(ops_pkg::OP_MOVE_FILE)));
      r_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit(paddr, ops_pkg::INSTR_OFFSET)) begin
          r_nxt.prdata[ops_pkg::OP_LSB +: ops_pkg::OP_W] = r_r.op;
          r_nxt.prdata[ops_pkg::DEST_BIT]                = r_r.dest;
          r_nxt.prdata[ops_pkg::K_LSB +: ops_pkg::K_W]   = r_r.k;
        end
        if (hit(paddr, ops_pkg::ACCUM_OFFSET)) begin
          r_nxt.prdata[ops_pkg::DATA_W-1:0] = r_r.w;
        end
        if (hit(paddr, ops_pkg::STATUS_OFFSET)) begin
          r_nxt.prdata[ops_pkg::ZERO_BIT] = r_r.zero;
          r_nxt.prdata[ops_pkg::SKIP_BIT] = r_r.skip;
        end
        if (hit(paddr, ops_pkg::LATCH_OFFSET)) begin
          r_nxt.prdata[ops_pkg::LATCH_W-1:0] = r_r.latch;
        end
        if (hit(paddr, ops_pkg::PC_OFFSET)) begin
          r_nxt.prdata[ops_pkg::PC_W-1:0] = r_r.pc;
        end
        if (hit(paddr, ops_pkg::FADDR_OFFSET)) begin
          r_nxt.prdata[ops_pkg::FILE_AW-1:0] = r_r.faddr;
        end
        if (hit(paddr, ops_pkg::FDATA_OFFSET)) begin
          r_nxt.prdata[ops_pkg::DATA_W-1:0] = ram_rdata;
        end
        if (hit(paddr, ops_pkg::CYCLES_OFFSET)) begin
          r_nxt.prdata[ops_pkg::CYCLES_W-1:0] = r_r.cycles;
        end
      end
    end

    // Register writes take effect at the completing edge only.
    if (commit) begin
      if (hit(paddr, ops_pkg::INSTR_OFFSET)) begin
        r_nxt.op    = ops_pkg::opcode_type'(wr_op);
        r_nxt.dest  = pwdata[ops_pkg::DEST_BIT];
        r_nxt.k     = pwdata[ops_pkg::K_LSB +: ops_pkg::K_W];
        r_nxt.state = ops_pkg::ST_FETCH;
      end
      if (hit(paddr, ops_pkg::ACCUM_OFFSET)) begin
        r_nxt.w = pwdata[ops_pkg::DATA_W-1:0];
      end
      if (hit(paddr, ops_pkg::STATUS_OFFSET)) begin
        r_nxt.zero = pwdata[ops_pkg::ZERO_BIT];
        r_nxt.skip = pwdata[ops_pkg::SKIP_BIT];
      end
      if (hit(paddr, ops_pkg::LATCH_OFFSET)) begin
        r_nxt.latch = pwdata[ops_pkg::LATCH_W-1:0];
      end
      if (hit(paddr, ops_pkg::PC_OFFSET)) begin
        r_nxt.pc = pwdata[ops_pkg::PC_W-1:0];
      end
      if (hit(paddr, ops_pkg::FADDR_OFFSET)) begin
        r_nxt.faddr = pwdata[ops_pkg::FILE_AW-1:0];
      end
      if (hit(paddr, ops_pkg::FDATA_OFFSET)) begin
        ram_we = 1'b1;
      end
    end

    unique case (r_r.state)
      ops_pkg::ST_IDLE: begin
      end
      ops_pkg::ST_FETCH: begin
        r_nxt.state = ops_pkg::ST_EXEC;
      end
      ops_pkg::ST_EXEC: begin
        r_nxt.cycles = r_r.cycles + 16'h0001;
        r_nxt.pc     = r_r.pc + 13'h0001;
        r_nxt.state  = ops_pkg::ST_IDLE;
        ram_waddr    = r_r.k[ops_pkg::FILE_AW-1:0];
        if (r_r.skip) begin
          // The instruction after a zero skip runs as a no-operation.
          r_nxt.skip = 1'b0;
        end else begin
          unique case (r_r.op)
            ops_pkg::OP_INCREMENT_FILE: begin
              result     = ram_rdata + 8'h01;
              r_nxt.zero = (result == 8'h00);
            end
            ops_pkg::OP_INCREMENT_SKIP_ZERO: begin
              result     = ram_rdata + 8'h01;
              r_nxt.skip = (result == 8'h00);
            end
            ops_pkg::OP_BRANCH_ABSOLUTE: begin
              r_nxt.pc    = {r_r.latch[ops_pkg::LATCH_PC_HI:ops_pkg::LATCH_PC_LO], r_r.k};
              r_nxt.state = ops_pkg::ST_FLUSH;
            end
            ops_pkg::OP_OR_LITERAL_W: begin
              result     = r_r.w | r_r.k[ops_pkg::DATA_W-1:0];
              r_nxt.zero = (result == 8'h00);
            end
            ops_pkg::OP_OR_W_FILE: begin
              result     = r_r.w | ram_rdata;
              r_nxt.zero = (result == 8'h00);
            end
            ops_pkg::OP_MOVE_FILE: begin
              result     = ram_rdata;
              r_nxt.zero = (result == 8'h00);
            end
            default: begin
            end
          endcase
          ram_wdata = result;
          // The selector bit picks accumulator or file register; the literal form always writes the accumulator.
          if (r_r.op == ops_pkg::OP_OR_LITERAL_W) begin
            r_nxt.w = result;
          end else if ((r_r.op == ops_pkg::OP_INCREMENT_FILE) || (r_r.op == ops_pkg::OP_INCREMENT_SKIP_ZERO) ||
                       (r_r.op == ops_pkg::OP_OR_W_FILE) || (r_r.op == ops_pkg::OP_MOVE_FILE)) begin
            if (r_r.dest) begin
              ram_we = 1'b1;
            end else begin
              r_nxt.w = result;
            end
          end
        end
      end
      ops_pkg::ST_FLUSH: begin
        // Second cycle of the branch: the already fetched word is discarded.
        r_nxt.cycles = r_r.cycles + 16'h0001;
        r_nxt.state  = ops_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r        <= '0;
      r_r.state  <= ops_pkg::ST_IDLE;
      r_r.op     <= ops_pkg::OP_NOP;
      r_r.w      <= ops_pkg::ACCUM_RESET;
      r_r.pc     <= ops_pkg::PC_RESET;
      r_r.latch  <= ops_pkg::LATCH_RESET;
      r_r.cycles <= ops_pkg::CYCLES_RESET;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

endmodule : exec_ops

// file: ops_pkg.sv
// Constants, field layouts and types shared by the execute block and its file memory.
package ops_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] INSTR_OFFSET  = 8'h00;
  localparam logic [7:0] ACCUM_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] LATCH_OFFSET  = 8'h0c;
  localparam logic [7:0] PC_OFFSET     = 8'h10;
  localparam logic [7:0] FADDR_OFFSET  = 8'h14;
  localparam logic [7:0] FDATA_OFFSET  = 8'h18;
  localparam logic [7:0] CYCLES_OFFSET = 8'h1c;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int K_LSB        = 0;
  localparam int K_W          = 11;
  localparam int DEST_BIT     = 11;
  localparam int OP_LSB       = 12;
  localparam int OP_W         = 3;
  localparam int FILE_AW      = 7;
  localparam int DATA_W       = 8;
  localparam int PC_W         = 13;
  localparam int LATCH_W      = 5;
  localparam int LATCH_PC_HI  = 4;
  localparam int LATCH_PC_LO  = 3;
  localparam int CYCLES_W     = 16;
  localparam int ZERO_BIT     = 0;
  localparam int SKIP_BIT     = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0]   ACCUM_RESET  = 8'h00;
  localparam logic [PC_W-1:0]     PC_RESET     = 13'h0000;
  localparam logic [LATCH_W-1:0]  LATCH_RESET  = 5'h00;
  localparam logic [CYCLES_W-1:0] CYCLES_RESET = 16'h0000;

  // ****************************************
  // Operation codes and sequencer states
  // ****************************************
  typedef enum logic [OP_W-1:0] {
    OP_NOP,
    OP_INCREMENT_FILE,
    OP_INCREMENT_SKIP_ZERO,
    OP_BRANCH_ABSOLUTE,
    OP_OR_LITERAL_W,
    OP_OR_W_FILE,
    OP_MOVE_FILE
  } opcode_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_FLUSH
  } exec_state_type;

endpackage : ops_pkg

// file: file_ram.sv
// File register memory with a registered read port and one write port.
`timescale 1ns/10ps
module file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          pclk,
  input  wire logic          ce,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule : file_ram

// file: exec_ops_asserts.sv
// Port assertions for the execute block.
`timescale 1ns/10ps
module exec_ops_asserts #(
  parameter int PADDR_W = 8
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               ce,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [7:0]         working_accumulator,
  input wire logic               zero_flag,
  input wire logic [12:0]        program_counter
);
  // ****
  // Decode of a completed instruction write, refused ones included.
  // ****
  logic       ins;
  logic       wdone;
  logic [2:0] op;
  assign wdone = pready && pwrite;
  assign ins = wdone && paddr == 'h0;
  assign op = pwdata[14:12];
  // ****
  // Expected program counter, due after the second enabled edge that follows the instruction write.
  // ****
  logic [12:0] exp_pc;
  logic        exp_br;
  logic [1:0]  pc_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_pc <= 13'h0000;
      exp_br <= 1'b0;
      pc_cnt <= 2'h0;
    end else if (ins && op != 3'h7) begin
      exp_pc <= (op == 3'h3) ? {2'h0, pwdata[10:0]} : program_counter + 13'h0001;
      exp_br <= (op == 3'h3);
      pc_cnt <= 2'h2;
    end else if (ce && pc_cnt != 2'h0) begin
      pc_cnt <= pc_cnt - 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  a_wait_state: assert property (psel && $rose(penable) |-> !pready ##[1:7] pready)
    else $error("access answered without a wait state or too late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && paddr > 'h1c |-> pslverr)
    else $error("unmapped address not refused");
  a_err_opcode: assert property (ins && op == 3'h7 |-> pslverr)
    else $error("undefined opcode not refused");
  a_write_rdata: assert property (wdone |-> prdata == 32'h0)
    else $error("read data not zero on a write");
  a_flags_kept: assert property (ins && (op == 3'h2 || op == 3'h3) |=> $stable(zero_flag) [*3])
    else $error("zero flag moved by skip or branch");
  a_pc_update: assert property (pc_cnt == 2'h1 && ce |=> (exp_br ? program_counter[10:0] == exp_pc[10:0] : program_counter == exp_pc))
    else $error("program counter not advanced or loaded");
  a_acc_cause: assert property ($changed(working_accumulator) |-> $past(wdone) || $past(wdone, 3))
    else $error("accumulator changed without a cause");
  c_skip: cover property (ins && op == 3'h2);
  c_branch: cover property (ins && op == 3'h3);
  c_refused: cover property (pslverr);
endmodule : exec_ops_asserts

bind exec_ops exec_ops_asserts #(.PADDR_W(PADDR_W)) i_asserts (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .working_accumulator(working_accumulator), .zero_flag(zero_flag), .program_counter(program_counter));

// file: test_exec_ops.sv
// Self-checking testbench for the execute block.
`timescale 1ns/10ps
module test_exec_ops;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, zero_flag, err;
  logic [7:0]  working_accumulator;
  logic [12:0] program_counter, epc = 13'h0;
  logic [4:0]  lat = 5'h00;
  int          fails = 0;
  int          n_compared = 0;
  int          ecyc = 0;
  exec_ops i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .working_accumulator(working_accumulator), .zero_flag(zero_flag), .program_counter(program_counter));
  always #2 pclk = ~pclk;
  // ****
  // Bus tasks.
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic r;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      r = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (r !== 1'b1 && n < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, r}, 32'h1);
    if (w && a == 8'h0c) lat = d[4:0];
    if (w && a == 8'h10) epc = d[12:0];
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic fset(input logic [7:0] a, input logic [7:0] v);
    wr(8'h14, {24'h0, a});
    wr(8'h18, {24'h0, v});
  endtask : fset
  task automatic fchk(input logic [7:0] a, input logic [7:0] e);
    wr(8'h14, {24'h0, a});
    rdc(8'h18, {24'h0, e});
  endtask : fchk
  task automatic ex(input logic [2:0] op, input logic d, input logic [10:0] k);
    wr(8'h00, {17'h0, op, d, k});
    epc = (op == 3'h3) ? {lat[4:3], k} : epc + 13'h1;
    ecyc += (op == 3'h3) ? 2 : 1;
    rdc(8'h10, {19'h0, epc});
  endtask : ex
  // ****
  // Scenarios.
  // ****
  task automatic t_inc;
    fset(8'h05, 8'hff);
    ex(3'h1, 1'b0, 11'h005);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h1);
    fchk(8'h05, 8'hff);
    fset(8'h06, 8'h41);
    ex(3'h1, 1'b1, 11'h706);
    fchk(8'h06, 8'h42);
    rdc(8'h08, 32'h0);
    chk({24'h0, working_accumulator}, 32'h0);
  endtask : t_inc
  task automatic t_skip;
    wr(8'h04, 32'h55);
    wr(8'h08, 32'h1);
    fset(8'h09, 8'hff);
    ex(3'h2, 1'b1, 11'h009);
    fchk(8'h09, 8'h00);
    rdc(8'h08, 32'h3);
    ex(3'h4, 1'b0, 11'h0aa);
    rdc(8'h04, 32'h55);
    rdc(8'h08, 32'h1);
    ex(3'h2, 1'b0, 11'h009);
    rdc(8'h04, 32'h1);
    rdc(8'h08, 32'h1);
    ex(3'h4, 1'b0, 11'h080);
    rdc(8'h04, 32'h81);
  endtask : t_skip
  task automatic t_branch;
    wr(8'h0c, 32'h18);
    wr(8'h08, 32'h0);
    ex(3'h3, 1'b0, 11'h7ff);
    rdc(8'h08, 32'h0);
    wr(8'h0c, 32'h07);
    wr(8'h08, 32'h1);
    ex(3'h3, 1'b1, 11'h123);
    chk({31'h0, zero_flag}, 32'h1);
  endtask : t_branch
  task automatic t_or;
    wr(8'h04, 32'h0);
    ex(3'h4, 1'b0, 11'h000);
    rdc(8'h08, 32'h1);
    ex(3'h4, 1'b1, 11'h0c3);
    rdc(8'h04, 32'hc3);
    rdc(8'h08, 32'h0);
    fset(8'h12, 8'h0c);
    wr(8'h04, 32'h30);
    ex(3'h5, 1'b1, 11'h012);
    fchk(8'h12, 8'h3c);
    rdc(8'h04, 32'h30);
    ex(3'h5, 1'b0, 11'h012);
    rdc(8'h04, 32'h3c);
  endtask : t_or
  task automatic t_move;
    fset(8'h7f, 8'h00);
    wr(8'h04, 32'h77);
    ex(3'h6, 1'b1, 11'h7ff);
    rdc(8'h08, 32'h1);
    rdc(8'h04, 32'h77);
    fchk(8'h7f, 8'h00);
    fset(8'h7f, 8'h5a);
    ex(3'h6, 1'b0, 11'h07f);
    rdc(8'h04, 32'h5a);
    rdc(8'h08, 32'h0);
  endtask : t_move
  task automatic t_hold;
    wr(8'h00, 32'h0000_0000);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({19'h0, program_counter}, {19'h0, epc});
    ce <= 1'b1;
    epc = epc + 13'h1;
    ecyc++;
    rdc(8'h10, {19'h0, epc});
  endtask : t_hold
  task automatic t_refuse;
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, 8'h1c, 32'h5);
    chk({31'h0, err}, 32'h1);
    rdc(8'h1c, ecyc);
    xfer(1'b1, 8'h00, 32'h7000);
    chk({31'h0, err}, 32'h1);
    rdc(8'h10, {19'h0, epc});
  endtask : t_refuse
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #40000;
    fails++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h1c, 32'h0);
    t_inc();
    t_skip();
    t_branch();
    t_or();
    t_move();
    t_hold();
    t_refuse();
    summarize();
  end
endmodule : test_exec_ops
